// >>> ccrb_regs.svh
`ifndef CCRB_REGS_SVH
`define CCRB_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets (command byte bits 6..0)
// ----------------------------------------------------------------------------
`define CCRB_OFS_COEF_SRC    7'h03
`define CCRB_OFS_FILT_COEF   7'h04
`define CCRB_OFS_OP_MODE     7'h05
`define CCRB_OFS_GAIN_GEN    7'h06
`define CCRB_OFS_ROUTING     7'h07
`define CCRB_OFS_METER_SRC   7'h08

// ----------------------------------------------------------------------------
// reset values and writable-bit masks
// ----------------------------------------------------------------------------
`define CCRB_RST_COEF_SRC    8'hFF
`define CCRB_RST_FILT_COEF   8'hBF
`define CCRB_RST_OP_MODE     8'h80
`define CCRB_RST_GAIN_GEN    8'h00
`define CCRB_RST_ROUTING     8'h00
`define CCRB_RST_METER_SRC   8'h00
`define CCRB_MSK_GAIN_GEN    8'h3F
`define CCRB_MSK_ROUTING     8'hBF
`define CCRB_MSK_FULL        8'hFF

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CCRB_CMD_WRITE_BIT   7
`define CCRB_MODE_PDN_BIT    7
`define CCRB_MODE_STBY_BIT   6
`define CCRB_MODE_ACT_BIT    5
`define CCRB_MODE_RAMP_BIT   4
`define CCRB_LINE_ACC_BIT    3
`define CCRB_RING_MODE_BIT   4
`define CCRB_RING_ON_BIT     2
`define CCRB_TONE2_BIT       1
`define CCRB_TONE1_BIT       0
`define CCRB_RAMP_ON_BIT     7
`define CCRB_MFILT_ON_BIT    4
`define CCRB_TDET_ON_BIT     0
`define CCRB_SHIFT_MAX       4'hB

`endif

// >>> ccrb_pkg.sv
package ccrb_pkg;

  // codec operating mode as decoded from the mode bits
  typedef enum logic [2:0] {
    CCRB_MODE_PDN,
    CCRB_MODE_STBY,
    CCRB_MODE_ACT,
    CCRB_MODE_RAMP,
    CCRB_MODE_RING
  } ccrb_mode_e;

  // line driver state field
  typedef logic [2:0] ccrb_line_t;

  // register index 0..5 for offsets 03..08
  typedef logic [2:0] ccrb_idx_t;

endpackage : ccrb_pkg

// >>> ccrb_shift.sv
`timescale 1ns/1ps
module ccrb_shift (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic       i_ce,
  input  wire logic       i_cs_b,
  input  wire logic       i_sclk,
  input  wire logic       i_sdi,
  input  wire logic       i_load,
  input  wire logic [7:0] i_load_byte,
  output logic            o_byte_vld,
  output logic [7:0]      o_byte,
  output logic            o_sdo,
  output logic            o_sdo_oe
);

  logic       sclk_q, sclk_d;
  logic [7:0] in_q, in_d, out_q, out_d;
  logic [2:0] cnt_q, cnt_d;
  logic       vld_q, vld_d, sdo_q, sdo_d, oe_q, oe_d;
  logic       rise, fall;

  // --------------------------------------------------------------------------
  // bit shifting: sample on sclk rise, present on sclk fall, msb first
  // --------------------------------------------------------------------------
  always_comb begin
    rise   = i_sclk & ~sclk_q;
    fall   = ~i_sclk & sclk_q;
    sclk_d = i_sclk;
    in_d   = in_q;
    out_d  = out_q;
    cnt_d  = cnt_q;
    vld_d  = 1'b0;
    sdo_d  = sdo_q;
    oe_d   = oe_q;
    if (i_cs_b) begin
      cnt_d = 3'h0;
      oe_d  = 1'b0;
    end else begin
      if (rise) begin
        in_d  = {in_q[6:0], i_sdi};
        cnt_d = cnt_q + 3'h1;
        vld_d = (cnt_q == 3'h7);
      end
      if (i_load) begin
        sdo_d = i_load_byte[7];
        out_d = i_load_byte;  // fall after the 8th rise re-presents the msb
        oe_d  = 1'b1;
      end else if (fall && oe_q) begin
        sdo_d = out_q[7];
        out_d = {out_q[6:0], 1'b0};
      end
    end
  end

  // register stage, frozen while clock enable is low
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_q <= 1'b0;
      in_q   <= 8'h00;
      out_q  <= 8'h00;
      cnt_q  <= 3'h0;
      vld_q  <= 1'b0;
      sdo_q  <= 1'b0;
      oe_q   <= 1'b0;
    end else if (i_ce) begin
      sclk_q <= sclk_d;
      in_q   <= in_d;
      out_q  <= out_d;
      cnt_q  <= cnt_d;
      vld_q  <= vld_d;
      sdo_q  <= sdo_d;
      oe_q   <= oe_d;
    end
  end

  assign o_byte_vld = vld_q;
  assign o_byte     = in_q;
  assign o_sdo      = sdo_q;
  assign o_sdo_oe   = oe_q;

endmodule : ccrb_shift

// >>> ccrb_decode.sv
`timescale 1ns/1ps
`include "ccrb_regs.svh"
module ccrb_decode (
  input  wire logic [7:0]          i_op_mode,
  input  wire logic [7:0]          i_gain_gen,
  input  wire logic [7:0]          i_meter_src,
  input  wire logic                i_host_port_mode,
  input  wire logic                i_ds_access,
  input  wire ccrb_pkg::ccrb_line_t i_ds_line_state,
  output ccrb_pkg::ccrb_mode_e     o_mode,
  output logic                     o_line_access,
  output ccrb_pkg::ccrb_line_t     o_line_state,
  output logic [3:0]               o_shift
);
  import ccrb_pkg::*;

  // clamp the meter shift code: codes above 1010 all mean 1/2048
  function automatic logic [3:0] clamp_shift(input logic [3:0] code);
    clamp_shift = (code > `CCRB_SHIFT_MAX) ? `CCRB_SHIFT_MAX : code;
  endfunction : clamp_shift

  // --------------------------------------------------------------------------
  // mode, line driver and shift decode
  // --------------------------------------------------------------------------
  always_comb begin
    // power down dominates, then ring, ramp, active; none set reads as standby
    if (i_op_mode[`CCRB_MODE_PDN_BIT])
      o_mode = CCRB_MODE_PDN;
    else if (i_gain_gen[`CCRB_RING_MODE_BIT])
      o_mode = CCRB_MODE_RING;
    else if (i_op_mode[`CCRB_MODE_RAMP_BIT])
      o_mode = CCRB_MODE_RAMP;
    else if (i_op_mode[`CCRB_MODE_ACT_BIT])
      o_mode = CCRB_MODE_ACT;
    else
      o_mode = CCRB_MODE_STBY;
    // register controls the line driver only in host-port mode
    if (i_host_port_mode) begin
      o_line_access = i_op_mode[`CCRB_LINE_ACC_BIT];
      o_line_state  = i_op_mode[2:0];
    end else begin
      o_line_access = i_ds_access;
      o_line_state  = i_ds_line_state;
    end
    o_shift = clamp_shift(i_meter_src[7:4]);
  end

endmodule : ccrb_decode

// >>> ccrb_top.sv
`timescale 1ns/1ps
`include "ccrb_regs.svh"
module ccrb_top (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_b,
  input  wire logic                 i_ce,
  input  wire logic                 i_cs_b,
  input  wire logic                 i_sclk,
  input  wire logic                 i_sdi,
  input  wire logic                 i_host_port_mode,
  input  wire logic                 i_ds_access,
  input  wire ccrb_pkg::ccrb_line_t i_ds_line_state,
  output logic                      o_sdo,
  output logic                      o_sdo_oe,
  output logic [7:0]                o_coef_src,
  output logic                      o_modem_lowpass_sel,
  output logic                      o_highpass_ctl,
  output logic [5:0]                o_coef_sel_misc,
  output ccrb_pkg::ccrb_mode_e      o_codec_mode,
  output logic                      o_line_access,
  output ccrb_pkg::ccrb_line_t      o_line_state,
  output logic                      o_impedance_scale_sel,
  output logic                      o_trip_method_sel,
  output logic                      o_ring_on,
  output logic                      o_tone2_on,
  output logic                      o_tone1_on,
  output logic                      o_ramp_on,
  output logic                      o_meter_filter_shape,
  output logic                      o_meter_filter_on,
  output logic                      o_meter_ac_dc_sel,
  output logic                      o_meter_dc_dir_sel,
  output logic                      o_tone_detect_dir_sel,
  output logic                      o_tone_detect_on,
  output logic [3:0]                o_meter_shift_factor,
  output logic [3:0]                o_meter_input_sel
);
  import ccrb_pkg::*;

  // --------------------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------------------

  // true when the offset lands inside this bank
  function automatic logic in_bank(input logic [6:0] ofs);
    in_bank = (ofs >= `CCRB_OFS_COEF_SRC) && (ofs <= `CCRB_OFS_METER_SRC);
  endfunction : in_bank

  // offset to storage index
  function automatic ccrb_idx_t ofs_idx(input logic [6:0] ofs);
    logic [6:0] diff;
    diff    = ofs - `CCRB_OFS_COEF_SRC;
    ofs_idx = diff[2:0];
  endfunction : ofs_idx

  // writable bits of each register; reserved bits stay zero
  function automatic logic [7:0] wr_mask(input ccrb_idx_t idx);
    case (idx)
      3'h3:    wr_mask = `CCRB_MSK_GAIN_GEN;
      3'h4:    wr_mask = `CCRB_MSK_ROUTING;
      default: wr_mask = `CCRB_MSK_FULL;
    endcase
  endfunction : wr_mask

  // --------------------------------------------------------------------------
  // reset release through two flip-flops
  // --------------------------------------------------------------------------
  logic rst_meta_q, rst_sync_b;

  // asynchronous assert, synchronous release
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_q <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_b <= rst_meta_q;
    end
  end

  // --------------------------------------------------------------------------
  // serial host port bytes
  // --------------------------------------------------------------------------
  logic       byte_vld;
  logic [7:0] byte_in;
  logic       rd_load;
  logic [7:0] rd_byte;

  ccrb_shift u_shift (
    .i_clk       (i_clk),
    .i_rst_b     (rst_sync_b),
    .i_ce        (i_ce),
    .i_cs_b      (i_cs_b),
    .i_sclk      (i_sclk),
    .i_sdi       (i_sdi),
    .i_load      (rd_load),
    .i_load_byte (rd_byte),
    .o_byte_vld  (byte_vld),
    .o_byte      (byte_in),
    .o_sdo       (o_sdo),
    .o_sdo_oe    (o_sdo_oe)
  );

  // --------------------------------------------------------------------------
  // command sequencer: command byte, then one data byte in or out
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    CCRB_ST_CMD,
    CCRB_ST_WDATA,
    CCRB_ST_RDATA
  } ccrb_state_e;

  ccrb_state_e st_q, st_d;
  logic [6:0]  ofs_q, ofs_d;
  logic [7:0]  regs_q [6];
  logic [7:0]  regs_d [6];
  logic        wr_hit;
  ccrb_idx_t   wr_idx;
  logic [7:0]  wr_val;

  // next state and read load
  always_comb begin
    st_d    = st_q;
    ofs_d   = ofs_q;
    rd_load = 1'b0;
    rd_byte = 8'h00;
    wr_hit  = 1'b0;
    wr_idx  = ofs_idx(ofs_q);
    wr_val  = byte_in & wr_mask(ofs_idx(ofs_q));
    if (i_cs_b) begin
      st_d = CCRB_ST_CMD;
    end else begin
      case (st_q)
        CCRB_ST_CMD: begin
          if (byte_vld) begin
            ofs_d = byte_in[6:0];
            if (byte_in[`CCRB_CMD_WRITE_BIT]) begin
              st_d = CCRB_ST_WDATA;
            end else begin
              st_d    = CCRB_ST_RDATA;
              rd_load = i_ce;
              // unmapped offsets answer zero
              if (in_bank(byte_in[6:0]))
                rd_byte = regs_q[ofs_idx(byte_in[6:0])];
            end
          end
        end
        CCRB_ST_WDATA: begin
          if (byte_vld) begin
            wr_hit = in_bank(ofs_q) && i_ce;
            st_d   = CCRB_ST_CMD;
          end
        end
        CCRB_ST_RDATA: begin
          if (byte_vld)
            st_d = CCRB_ST_CMD;
        end
        default: st_d = CCRB_ST_CMD;
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge i_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_q  <= CCRB_ST_CMD;
      ofs_q <= 7'h00;
    end else if (i_ce) begin
      st_q  <= st_d;
      ofs_q <= ofs_d;
    end
  end

  // --------------------------------------------------------------------------
  // configuration storage
  // --------------------------------------------------------------------------
  // write the addressed register with reserved bits forced low
  always_comb begin
    for (int i = 0; i < 6; i++)
      regs_d[i] = regs_q[i];
    if (wr_hit)
      regs_d[wr_idx] = wr_val;
  end

  // storage flops with documented reset values
  always_ff @(posedge i_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      regs_q[0] <= `CCRB_RST_COEF_SRC;
      regs_q[1] <= `CCRB_RST_FILT_COEF;
      regs_q[2] <= `CCRB_RST_OP_MODE;
      regs_q[3] <= `CCRB_RST_GAIN_GEN;
      regs_q[4] <= `CCRB_RST_ROUTING;
      regs_q[5] <= `CCRB_RST_METER_SRC;
    end else if (i_ce) begin
      for (int i = 0; i < 6; i++)
        regs_q[i] <= regs_d[i];
    end
  end

  logic [7:0] r_coef, r_filt, r_mode, r_gain, r_rout, r_meter;
  assign r_coef  = regs_q[0];
  assign r_filt  = regs_q[1];
  assign r_mode  = regs_q[2];
  assign r_gain  = regs_q[3];
  assign r_rout  = regs_q[4];
  assign r_meter = regs_q[5];

  // --------------------------------------------------------------------------
  // decode and output registers
  // --------------------------------------------------------------------------
  ccrb_mode_e mode_c;
  logic       acc_c;
  ccrb_line_t line_c;
  logic [3:0] shift_c;

  ccrb_decode u_decode (
    .i_op_mode        (r_mode),
    .i_gain_gen       (r_gain),
    .i_meter_src      (r_meter),
    .i_host_port_mode (i_host_port_mode),
    .i_ds_access      (i_ds_access),
    .i_ds_line_state  (i_ds_line_state),
    .o_mode           (mode_c),
    .o_line_access    (acc_c),
    .o_line_state     (line_c),
    .o_shift          (shift_c)
  );

  logic [7:0] coef_q, coef_d;
  logic       lp_q, lp_d, hp_q, hp_d;
  logic [5:0] misc_q, misc_d;
  ccrb_mode_e mode_q, mode_d;
  logic       acc_q, acc_d;
  ccrb_line_t line_q, line_d;
  logic [3:0] gen_q, gen_d;
  logic [8:0] rout_q, rout_d;
  logic [3:0] shift_q, shift_d;
  logic [3:0] msel_q, msel_d;

  // spread register fields onto the steering outputs
  always_comb begin
    coef_d  = r_coef;
    lp_d    = r_filt[7];
    hp_d    = r_filt[6];
    misc_d  = r_filt[5:0];
    mode_d  = mode_c;
    acc_d   = acc_c;
    line_d  = line_c;
    gen_d   = {r_gain[5], r_gain[3], r_gain[`CCRB_RING_ON_BIT],
               r_gain[`CCRB_TONE2_BIT]};
    rout_d  = {r_gain[`CCRB_TONE1_BIT], r_rout[`CCRB_RAMP_ON_BIT],
               r_rout[5:0], 1'b0};
    shift_d = shift_c;
    msel_d  = r_meter[3:0];
  end

  // output flops
  always_ff @(posedge i_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      coef_q  <= `CCRB_RST_COEF_SRC;
      lp_q    <= 1'b1;
      hp_q    <= 1'b0;
      misc_q  <= 6'h3F;
      mode_q  <= CCRB_MODE_PDN;
      acc_q   <= 1'b0;
      line_q  <= 3'h0;
      gen_q   <= 4'h0;
      rout_q  <= 9'h000;
      shift_q <= 4'h0;
      msel_q  <= 4'h0;
    end else if (i_ce) begin
      coef_q  <= coef_d;
      lp_q    <= lp_d;
      hp_q    <= hp_d;
      misc_q  <= misc_d;
      mode_q  <= mode_d;
      acc_q   <= acc_d;
      line_q  <= line_d;
      gen_q   <= gen_d;
      rout_q  <= rout_d;
      shift_q <= shift_d;
      msel_q  <= msel_d;
    end
  end

  assign o_coef_src            = coef_q;
  assign o_modem_lowpass_sel   = lp_q;
  assign o_highpass_ctl        = hp_q;
  assign o_coef_sel_misc       = misc_q;
  assign o_codec_mode          = mode_q;
  assign o_line_access         = acc_q;
  assign o_line_state          = line_q;
  assign o_impedance_scale_sel = gen_q[3];
  assign o_trip_method_sel     = gen_q[2];
  assign o_ring_on             = gen_q[1];
  assign o_tone2_on            = gen_q[0];
  assign o_tone1_on            = rout_q[8];
  assign o_ramp_on             = rout_q[7];
  assign o_meter_filter_shape  = rout_q[6];
  assign o_meter_filter_on     = rout_q[5];
  assign o_meter_ac_dc_sel     = rout_q[4];
  assign o_meter_dc_dir_sel    = rout_q[3];
  assign o_tone_detect_dir_sel = rout_q[2];
  assign o_tone_detect_on      = rout_q[1];
  assign o_meter_shift_factor  = shift_q;
  assign o_meter_input_sel     = msel_q;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  logic rd_msb;
  assign rd_msb = rd_byte[7];

  write_takes_a: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    wr_hit |=> regs_q[$past(wr_idx)] == $past(wr_val))
    else $error("register write not stored");

  reserved_zero_a: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    (r_gain[7:6] == 2'b00) && (r_rout[6] == 1'b0))
    else $error("reserved bit set");

  reset_values_a: assert property (@(posedge i_clk)
    $rose(rst_sync_b) |-> (r_coef == 8'hFF) && (r_filt == 8'hBF)
                          && (r_mode == 8'h80) && (r_gain == 8'h00))
    else $error("wrong reset value");

  line_ctl_a: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    (i_ce && !i_host_port_mode) |=> o_line_access == $past(i_ds_access)
                                    && o_line_state == $past(i_ds_line_state))
    else $error("line control not from downstream byte");

  shift_clamp_a: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    (i_ce && r_meter[7:4] >= 4'hB) |=> o_meter_shift_factor == 4'hB)
    else $error("meter shift not clamped");

  power_down_a: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    (i_ce && r_mode[7]) |=> o_codec_mode == CCRB_MODE_PDN)
    else $error("power down not applied");

  tone_enable_a: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    i_ce |=> o_tone1_on == $past(r_gain[0]) && o_tone2_on == $past(r_gain[1]))
    else $error("tone enable mismatch");

  read_answer_a: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    rd_load |=> o_sdo_oe && (o_sdo == $past(rd_msb)))
    else $error("read data not presented");

  ramp_route_a: assert property (@(posedge i_clk) disable iff (!rst_sync_b)
    i_ce |=> o_ramp_on == $past(r_rout[7]))
    else $error("ramp generator enable mismatch");

endmodule : ccrb_top

// >>> ccrb_host.sv
`timescale 1ns/1ps
// ----
// serial host processor model
// ----
module ccrb_host (
  input  wire logic i_clk,
  input  wire logic i_sdo,
  output logic      o_cs_b,
  output logic      o_sclk,
  output logic      o_sdi
);
  // idle: deselected, clock parked low
  initial begin
    o_cs_b = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end
  // one frame of n sclk periods, each phase four clocks
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int n,
                      output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(negedge i_clk);
    o_cs_b = 1'b0;
    for (int i = 0; i < n; i++) begin
      o_sdi = sh[15-i];
      repeat (4) @(negedge i_clk);
      if (i > 7) rd[15-i] = i_sdo; // read bit taken as sclk rises
      o_sclk = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    repeat (3) @(negedge i_clk);
    o_cs_b = 1'b1;
    o_sdi = ~o_sdi; // released line shows no stale value
    repeat (4) @(negedge i_clk);
  endtask : xfer
endmodule : ccrb_host

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
  import ccrb_pkg::*;
  logic i_clk, i_rst_b, i_ce, i_cs_b, i_sclk, i_sdi, i_host_port_mode, i_ds_access, sdo_w;
  ccrb_line_t i_ds_line_state, o_line_state;
  ccrb_mode_e o_codec_mode;
  logic o_sdo, o_sdo_oe, o_modem_lowpass_sel, o_highpass_ctl, o_line_access, o_ring_on;
  logic o_impedance_scale_sel, o_trip_method_sel, o_tone2_on, o_tone1_on, o_ramp_on;
  logic o_meter_filter_shape, o_meter_filter_on, o_meter_ac_dc_sel, o_meter_dc_dir_sel;
  logic o_tone_detect_dir_sel, o_tone_detect_on;
  logic [7:0] o_coef_src, seed, rdv;
  logic [5:0] o_coef_sel_misc;
  logic [3:0] o_meter_shift_factor, o_meter_input_sel;
  logic [7:0] exp_q [6];
  logic [6:0] bad [4] = '{7'h02, 7'h09, 7'h0A, 7'h7F};
  int failures, comparisons;
  // ----
  // design, host model and read data wire
  // ----
  ccrb_top ccrb_top_i (.i_clk, .i_rst_b, .i_ce, .i_cs_b, .i_sclk, .i_sdi, .i_host_port_mode,
    .i_ds_access, .i_ds_line_state, .o_sdo, .o_sdo_oe, .o_coef_src, .o_modem_lowpass_sel,
    .o_highpass_ctl, .o_coef_sel_misc, .o_codec_mode, .o_line_access, .o_line_state,
    .o_impedance_scale_sel, .o_trip_method_sel, .o_ring_on, .o_tone2_on, .o_tone1_on,
    .o_ramp_on, .o_meter_filter_shape, .o_meter_filter_on, .o_meter_ac_dc_sel,
    .o_meter_dc_dir_sel, .o_tone_detect_dir_sel, .o_tone_detect_on, .o_meter_shift_factor,
    .o_meter_input_sel);
  ccrb_host ccrb_host_i (.i_clk, .i_sdo(sdo_w), .o_cs_b(i_cs_b), .o_sclk(i_sclk), .o_sdi(i_sdi));
  assign sdo_w = o_sdo_oe ? o_sdo : i_clk; // undriven line toggles
  // clock
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end
  // ----
  // helpers
  // ----
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic ccrb_mode_e mode_of(input logic [7:0] m, input logic ring);
    if (m[7]) return CCRB_MODE_PDN;
    if (ring) return CCRB_MODE_RING;
    if (m[4]) return CCRB_MODE_RAMP;
    if (m[5]) return CCRB_MODE_ACT;
    return CCRB_MODE_STBY;
  endfunction : mode_of
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] want);
    comparisons++;
    if (got !== want) begin
      failures++;
      $display("MISMATCH t=%0t readback %h want %h", $time, got, want);
    end
  endtask : chk_reg
  task automatic chk_out(input logic [7:0] got, input logic [7:0] want);
    comparisons++;
    if (got !== want) begin
      failures++;
      $display("MISMATCH t=%0t output %h want %h", $time, got, want);
    end
  endtask : chk_out
  task automatic conclude;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
    ccrb_host_i.xfer({1'b1, a}, d, n, rdv);
    if (n == 16 && a >= 7'h03 && a <= 7'h08)
      exp_q[a-3] = d & ((a == 7'h06) ? 8'h3F : (a == 7'h07) ? 8'hBF : 8'hFF);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] want);
    ccrb_host_i.xfer({1'b0, a}, seed, 16, rdv);
    chk_reg(rdv, want);
  endtask : rd
  // drive line inputs at random (host-port mode forced on when hm is set), then check every output except o_sdo and read back all six registers
  task automatic check_all(input logic hm);
    logic [7:0] m;
    seed = lfsr(seed);
    i_host_port_mode = seed[0] | hm;
    i_ds_access = seed[1];
    i_ds_line_state = seed[4:2];
    repeat (3) @(negedge i_clk);
    m = exp_q[2];
    chk_out({7'h00, o_sdo_oe}, 8'h00);
    chk_out(o_coef_src, exp_q[0]);
    chk_out({o_modem_lowpass_sel, o_highpass_ctl, o_coef_sel_misc}, exp_q[1]);
    chk_out({5'h00, o_codec_mode}, {5'h00, mode_of(m, exp_q[3][4])});
    chk_out({4'h0, o_line_access, o_line_state},
            {4'h0, i_host_port_mode ? m[3:0] : {i_ds_access, i_ds_line_state}});
    chk_out({3'h0, o_impedance_scale_sel, o_trip_method_sel, o_ring_on, o_tone2_on, o_tone1_on},
            {3'h0, exp_q[3][5], exp_q[3][3:0]});
    chk_out({o_ramp_on, 1'b0, o_meter_filter_shape, o_meter_filter_on, o_meter_ac_dc_sel,
             o_meter_dc_dir_sel, o_tone_detect_dir_sel, o_tone_detect_on}, exp_q[4]);
    chk_out({o_meter_shift_factor, o_meter_input_sel},
            {(exp_q[5][7:4] > 4'hA) ? 4'hB : exp_q[5][7:4], exp_q[5][3:0]});
    for (int r = 0; r < 6; r++) rd(7'(r + 3), exp_q[r]);
  endtask : check_all
  // ----
  // main sequence
  // ----
  initial begin
    i_rst_b = 1'b0;
    i_ce = 1'b1;
    i_host_port_mode = 1'b1;
    i_ds_access = 1'b0;
    i_ds_line_state = 3'h0;
    seed = 8'h0C;
    failures = 0;
    comparisons = 0;
    exp_q = '{8'hFF, 8'hBF, 8'h80, 8'h00, 8'h00, 8'h00};
    repeat (4) @(negedge i_clk);
    i_rst_b = 1'b1;
    repeat (4) @(negedge i_clk);
    check_all(1'b0);
    $display("test reset values done");
    for (int p = 0; p < 2; p++) begin
      for (int r = 0; r < 6; r++) wr(7'(r + 3), p ? 8'h00 : 8'hFF, 16);
      check_all(1'b0);
    end
    $display("test all ones and zeros done");
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      wr(7'h05, {k[3:0], k[3:0]}, 16);
      wr(7'h06, {seed[7:5], k[0] & k[2], seed[3:0]}, 16);
      wr(7'h08, {k[3:0], ~k[3:0]}, 16);
      check_all(1'b1);
    end
    $display("test mode line shift codes done");
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      wr(7'(seed % 6 + 3), lfsr(seed), 16);
      check_all(1'b0);
    end
    $display("test random writes done");
    for (int i = 0; i < 4; i++) begin
      wr(bad[i], seed, 16);
      rd(bad[i], 8'h00);
    end
    wr(7'h03, ~exp_q[0], 12);
    check_all(1'b0);
    $display("test unmapped and aborted done");
    i_ce = 1'b0;
    ccrb_host_i.xfer({1'b1, 7'h03}, ~exp_q[0], 16, rdv);
    i_ce = 1'b1;
    check_all(1'b0);
    $display("test clock enable freeze done");
    conclude;
  end
  // watchdog
  initial begin
    #1900000;
    failures++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    conclude;
  end
endmodule : testbench
